// [design/rtd_core.sv]
// Real-time clock top: slow clock divider, seconds and day counters, alarm and flags.
//
// Contract
// - Divide the slow clock to one tick per second on the crystal, one per 1.024 s on the RC source; only the tick advances time.
// - Seconds counter is 17 bits, counts 0 to 86399, then returns to zero.
// - Each seconds wrap increments the 15-bit day counter by one unless a day write lands in the same cycle.
// - Day counter covers its full range up to 32767.
// - Every second tick raises the second-tick interrupt event.
// - Second-tick mask set keeps that event off the host interrupt.
// - Host-programmable alarm seconds and alarm day values define the alarm moment.
// - Alarm flag rises when both seconds and day equal the alarm values.
// - Alarm acts as turn-on event only when off; it interrupts both when off and when on.
// - Without a crystal an internal 32 kHz RC source clocks the timekeeping.
// - Slow clock is driven out as a square wave and feeds internal ticks.
// - Time counters are not synchronised against host accesses.
// - Host frame: write bit, 6 address bits, null bit, 24 data bits.
// - Written data takes effect only at the falling edge of the 32nd clock.
`timescale 1ns/1ps
module rtd_core
	import rtd_pkg::*;
#(
	parameter int PRESCALE_DIV = PRESCALE_DEFAULT
) (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic crystal_present_in,
	input wire logic system_on_in,
	input wire logic second_tick_mask_in,
	input wire logic alarm_match_mask_in,
	input wire logic second_tick_clear_in,
	input wire logic alarm_match_clear_in,
	input wire logic spi_clk_in,
	input wire logic spi_cs_in,
	input wire logic spi_mosi_in,
	output logic spi_miso_out,
	output logic spi_miso_oe_n_out,
	output logic slow_clock_out,
	output logic second_tick_irq_out,
	output logic alarm_match_irq_out,
	output logic host_irq_out,
	output logic turn_on_event_out,
	output logic [TOD_W-1:0] seconds_of_day_counter_out,
	output logic [DAY_W-1:0] elapsed_day_counter_out
);
	localparam int SUB_W = (PRESCALE_DIV > 2) ? $clog2(PRESCALE_DIV) : 1;
	localparam logic [SUB_W-1:0] SUB_LAST = SUB_W'(PRESCALE_DIV - 1);

	function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] reg_a);
		hit = (addr == reg_a);
	endfunction

	// ----------------------------------------------------------------
	// Host port
	// ----------------------------------------------------------------
	logic wr_stb;
	logic [ADDR_W-1:0] wr_addr;
	logic [DATA_W-1:0] wr_data;
	logic [ADDR_W-1:0] rd_addr;
	logic [DATA_W-1:0] rd_data;
	logic [TOD_W-1:0] seconds_of_day_counter;
	logic [DAY_W-1:0] day;
	logic [TOD_W-1:0] alarm_seconds_value;
	logic [DAY_W-1:0] alarm_day_value;

	rtd_serial_port u_port (
		.ref_clk_in(ref_clk_in),
		.rst_in(rst_in),
		.spi_clk_in(spi_clk_in),
		.spi_cs_in(spi_cs_in),
		.spi_mosi_in(spi_mosi_in),
		.rd_data_in(rd_data),
		.rd_addr_out(rd_addr),
		.spi_miso_out(spi_miso_out),
		.spi_miso_oe_n_out(spi_miso_oe_n_out),
		.wr_stb_out(wr_stb),
		.wr_addr_out(wr_addr),
		.wr_data_out(wr_data)
	);

	wire tod_wr = wr_stb & hit(wr_addr, ADDR_TIME);
	wire day_wr = wr_stb & hit(wr_addr, ADDR_DAY);
	wire alarm_sec_wr = wr_stb & hit(wr_addr, ADDR_ALARM);
	wire alarm_day_wr = wr_stb & hit(wr_addr, ADDR_DAY_ALARM);
	wire [TOD_W-1:0] tod_wr_val = wr_data[TOD_W-1:0];
	wire [DAY_W-1:0] day_wr_val = wr_data[DAY_W-1:0];

	// Both domains share one clock here, so each read word is coherent on its own;
	// seconds and day are still separate frames and may straddle a tick.
	assign rd_data = hit(rd_addr, ADDR_TIME) ? {7'h00, seconds_of_day_counter} :
		hit(rd_addr, ADDR_ALARM) ? {7'h00, alarm_seconds_value} :
		hit(rd_addr, ADDR_DAY) ? {9'h000, day} :
		hit(rd_addr, ADDR_DAY_ALARM) ? {9'h000, alarm_day_value} : 24'h00_0000;

	// ----------------------------------------------------------------
	// Slow clock generation
	// ----------------------------------------------------------------
	logic [ACC_W-1:0] acc;
	logic [SUB_W-1:0] sub_cnt;
	wire [ACC_W-1:0] inc = crystal_present_in ? XTAL_INC : RC_INC;
	wire [ACC_W-1:0] acc_sum = acc + inc;
	wire half_pulse = (acc_sum >= CLK_HZ_W);
	wire slow_tick = half_pulse & ~slow_clock_out;
	// A time write restarts the sub-second phase and cancels a tick in the same cycle.
	wire sec_tick = slow_tick & (sub_cnt == SUB_LAST) & ~tod_wr;
	wire tod_wrap = sec_tick & (seconds_of_day_counter >= TOD_LAST);

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			acc <= 27'h000_0000;
			slow_clock_out <= 1'b0;
			sub_cnt <= '0;
		end else begin
			acc <= half_pulse ? acc_sum - CLK_HZ_W : acc_sum;
			slow_clock_out <= slow_clock_out ^ half_pulse;
			if (tod_wr) begin
				sub_cnt <= '0;
			end else if (slow_tick) begin
				sub_cnt <= (sub_cnt == SUB_LAST) ? '0 : sub_cnt + 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Time, day and alarm registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			seconds_of_day_counter <= TOD_RST;
			day <= DAY_RST;
			alarm_seconds_value <= ALARM_SEC_RST;
			alarm_day_value <= ALARM_DAY_RST;
		end else begin
			if (tod_wr) begin
				seconds_of_day_counter <= tod_wr_val;
			end else if (sec_tick) begin
				seconds_of_day_counter <= tod_wrap ? TOD_RST : seconds_of_day_counter + 17'h0_0001;
			end
			if (day_wr) begin
				day <= day_wr_val;
			end else if (tod_wrap) begin
				day <= day + 15'h0001;
			end
			if (alarm_sec_wr) begin
				alarm_seconds_value <= tod_wr_val;
			end
			if (alarm_day_wr) begin
				alarm_day_value <= day_wr_val;
			end
		end
	end

	assign seconds_of_day_counter_out = seconds_of_day_counter;
	assign elapsed_day_counter_out = day;

	// ----------------------------------------------------------------
	// Alarm compare, flags and host interrupt
	// ----------------------------------------------------------------
	logic match_q;
	wire match_now = (seconds_of_day_counter == alarm_seconds_value) & (day == alarm_day_value);
	// Only the moment of reaching the alarm counts, so a standing match does not refire.
	wire alarm_event = match_now & ~match_q;

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			match_q <= 1'b0;
			second_tick_irq_out <= 1'b0;
			alarm_match_irq_out <= 1'b0;
			host_irq_out <= 1'b0;
			turn_on_event_out <= 1'b0;
		end else begin
			match_q <= match_now;
			// A set arriving with a clear wins.
			second_tick_irq_out <= sec_tick | (second_tick_irq_out & ~second_tick_clear_in);
			alarm_match_irq_out <= alarm_event | (alarm_match_irq_out & ~alarm_match_clear_in);
			host_irq_out <= (second_tick_irq_out & ~second_tick_mask_in) |
				(alarm_match_irq_out & ~alarm_match_mask_in);
			turn_on_event_out <= alarm_event & ~system_on_in;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	tod_wrap_zero_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		tod_wrap |=> (seconds_of_day_counter == TOD_RST)) else $error("seconds did not return to zero");
	tod_step_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(sec_tick && seconds_of_day_counter < TOD_LAST) |=> (seconds_of_day_counter == $past(seconds_of_day_counter) + 17'h0_0001))
		else $error("seconds did not advance by one");
	day_increment_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(tod_wrap && !day_wr) |=> (day == $past(day) + 15'h0001))
		else $error("day did not advance on wrap");
	tod_hold_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(!sec_tick && !tod_wr) |=> $stable(seconds_of_day_counter)) else $error("seconds moved without a tick");
	tick_spacing_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		sec_tick |=> !sec_tick [*2]) else $error("second ticks too close");
	tick_flag_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		sec_tick |=> second_tick_irq_out) else $error("tick flag not set");
	flag_sticky_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(alarm_match_irq_out && !alarm_match_clear_in) |=> alarm_match_irq_out)
		else $error("alarm flag dropped without clear");
	tick_mask_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(second_tick_mask_in && !(alarm_match_irq_out && !alarm_match_mask_in)) |=> !host_irq_out)
		else $error("masked tick reached host interrupt");
	alarm_flag_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		(match_now && !match_q) |=> alarm_match_irq_out) else $error("alarm match missed");
	turn_on_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		$rose(match_now) |=> (turn_on_event_out == !$past(system_on_in)))
		else $error("turn-on event wrong for power state");
	tod_load_a: assert property (@(posedge ref_clk_in) disable iff (rst_in)
		tod_wr |=> (seconds_of_day_counter == $past(tod_wr_val)) ##1 !sec_tick) else $error("time write not loaded");
endmodule // rtd_core

// [design/rtd_pkg.sv]
// Shared constants for the real-time clock with time-of-day, day count and alarm.
package rtd_pkg;
	// ----------------------------------------------------------------
	// Clock rates
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 50_000_000;
	localparam int XTAL_HZ = 32768;
	localparam int RC_HZ = 32000;
	localparam int ACC_W = 27;
	localparam logic [ACC_W-1:0] CLK_HZ_W = ACC_W'(CLK_HZ);
	// The accumulator runs at twice the slow rate so that each overflow is one half period.
	localparam logic [ACC_W-1:0] XTAL_INC = ACC_W'(2 * XTAL_HZ);
	localparam logic [ACC_W-1:0] RC_INC = ACC_W'(2 * RC_HZ);
	localparam int PRESCALE_DEFAULT = XTAL_HZ;

	// ----------------------------------------------------------------
	// Counters and reset values
	// ----------------------------------------------------------------
	localparam int TOD_W = 17;
	localparam int DAY_W = 15;
	localparam logic [TOD_W-1:0] TOD_LAST = 17'h1_517F;
	localparam logic [TOD_W-1:0] TOD_RST = 17'h0_0000;
	localparam logic [DAY_W-1:0] DAY_RST = 15'h0000;
	// Unreachable seconds value, so that no alarm fires before software sets one.
	localparam logic [TOD_W-1:0] ALARM_SEC_RST = 17'h1_FFFF;
	localparam logic [DAY_W-1:0] ALARM_DAY_RST = 15'h0000;

	// ----------------------------------------------------------------
	// Serial port framing and register addresses
	// ----------------------------------------------------------------
	localparam int DATA_W = 24;
	localparam int ADDR_W = 6;
	localparam logic [5:0] HDR_BITS = 6'h08;
	localparam logic [5:0] FRAME_BITS = 6'h20;
	localparam logic [5:0] FRAME_DONE = 6'h21;
	localparam logic [ADDR_W-1:0] ADDR_TIME = 6'h14;
	localparam logic [ADDR_W-1:0] ADDR_ALARM = 6'h15;
	localparam logic [ADDR_W-1:0] ADDR_DAY = 6'h16;
	localparam logic [ADDR_W-1:0] ADDR_DAY_ALARM = 6'h17;
endpackage

// [design/rtd_serial_port.sv]
// Serial control port slave: 32-bit frames, commit on the falling edge of the 32nd clock.
`timescale 1ns/1ps
module rtd_serial_port
	import rtd_pkg::*;
(
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic spi_clk_in,
	input wire logic spi_cs_in,
	input wire logic spi_mosi_in,
	input wire logic [DATA_W-1:0] rd_data_in,
	output logic [ADDR_W-1:0] rd_addr_out,
	output logic spi_miso_out,
	output logic spi_miso_oe_n_out,
	output logic wr_stb_out,
	output logic [ADDR_W-1:0] wr_addr_out,
	output logic [DATA_W-1:0] wr_data_out
);
	// ----------------------------------------------------------------
	// Edge detection of the sampled serial clock
	// ----------------------------------------------------------------
	// The serial clock is sampled by the system clock, so it must stay below a quarter of it.
	logic sclk_q;
	logic [5:0] bit_cnt;
	logic [31:0] shift_in;
	logic [DATA_W-1:0] out_sr;

	wire sclk_rise = spi_cs_in & spi_clk_in & ~sclk_q & (bit_cnt < FRAME_BITS);
	wire sclk_fall = spi_cs_in & ~spi_clk_in & sclk_q;
	wire frame_end = sclk_fall & (bit_cnt == FRAME_BITS);
	wire load_rd = sclk_fall & (bit_cnt == HDR_BITS);
	wire shift_rd = sclk_fall & (bit_cnt > HDR_BITS) & (bit_cnt < FRAME_BITS);
	// Header is write flag, six address bits and one null bit; data follows MSB first.
	wire is_write = shift_in[31];
	wire [ADDR_W-1:0] frame_addr = shift_in[30:25];

	assign rd_addr_out = shift_in[6:1];
	assign spi_miso_out = out_sr[DATA_W-1];
	assign spi_miso_oe_n_out = ~spi_cs_in;

	// ----------------------------------------------------------------
	// Frame shifting
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			sclk_q <= 1'b0;
			bit_cnt <= 6'h00;
			shift_in <= 32'h0000_0000;
			out_sr <= 24'h00_0000;
		end else begin
			sclk_q <= spi_clk_in;
			if (!spi_cs_in) begin
				// A frame cut short by chip select is dropped whole.
				bit_cnt <= 6'h00;
				out_sr <= 24'h00_0000;
			end else if (sclk_rise) begin
				shift_in <= {shift_in[30:0], spi_mosi_in};
				bit_cnt <= bit_cnt + 6'h01;
			end else if (frame_end) begin
				bit_cnt <= FRAME_DONE;
			end
			if (spi_cs_in && load_rd) begin
				out_sr <= rd_data_in;
			end else if (spi_cs_in && shift_rd) begin
				out_sr <= {out_sr[DATA_W-2:0], 1'b0};
			end
		end
	end

	// ----------------------------------------------------------------
	// Write strobe
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			wr_stb_out <= 1'b0;
			wr_addr_out <= 6'h00;
			wr_data_out <= 24'h00_0000;
		end else begin
			wr_stb_out <= frame_end & is_write;
			if (frame_end) begin
				wr_addr_out <= frame_addr;
				wr_data_out <= shift_in[DATA_W-1:0];
			end
		end
	end
endmodule // rtd_serial_port

// [tb/rtd_host_model.sv]
// Host processor model that drives 32-bit serial frames into the clock core.
`timescale 1ns/1ps
module rtd_host_model (
	input wire logic ref_clk_in,
	input wire logic spi_miso_in,
	output logic spi_clk_out,
	output logic spi_cs_out,
	output logic spi_mosi_out
);
	// The serial clock stands still low between frames, as a real host leaves it.
	initial begin
		spi_clk_out = 1'b0;
		spi_cs_out = 1'b0;
		spi_mosi_out = 1'b0;
	end
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk_in);
		#1;
	endtask
	// Select drops after stop_at bits; 32 sends the whole frame.
	task automatic frame(input logic wr, input logic [5:0] addr, input logic [23:0] data,
		input int stop_at, output logic [23:0] rd);
		logic [31:0] word;
		word = {wr, addr, 1'b0, data};
		rd = 24'h00_0000;
		step(1);
		spi_cs_out = 1'b1;
		for (int i = 31; i >= 0; i--) begin
			if (31 - i == stop_at) break;
			spi_mosi_out = word[i];
			step(3);
			spi_clk_out = 1'b1;
			if (i < 24) rd[i] = spi_miso_in;
			step(3);
			spi_clk_out = 1'b0;
		end
		step(2);
		spi_cs_out = 1'b0;
		// Released data line shows the inverse so a stale bit cannot pass for a driven one.
		spi_mosi_out = ~spi_mosi_out;
	endtask
endmodule // rtd_host_model

// [tb/tb.sv]
// Self-checking bench for the real-time clock core.
`timescale 1ns/1ps
module tb
	import rtd_pkg::*;
;
	logic ref_clk_in, rst_in, crystal_present_in, system_on_in, spi_clk_in, spi_cs_in;
	logic second_tick_mask_in, alarm_match_mask_in, second_tick_clear_in, alarm_match_clear_in;
	logic spi_mosi_in, spi_miso_out, spi_miso_oe_n_out, slow_clock_out, second_tick_irq_out;
	logic alarm_match_irq_out, host_irq_out, turn_on_event_out;
	logic [TOD_W-1:0] seconds_of_day_counter_out;
	logic [DAY_W-1:0] elapsed_day_counter_out;
	logic [23:0] rd;
	int fails = 0;
	int num_checks = 0;
	int exp_sec, exp_day, wake_cnt, r, per;
	// A released data line shows the inverse, so a stale bit cannot pass for a driven one.
	wire logic miso_line = spi_miso_oe_n_out ? ~spi_miso_out : spi_miso_out;
	rtd_core #(.PRESCALE_DIV(2)) rtd_core_i (.ref_clk_in, .rst_in, .crystal_present_in,
		.system_on_in, .second_tick_mask_in, .alarm_match_mask_in, .second_tick_clear_in,
		.alarm_match_clear_in, .spi_clk_in, .spi_cs_in, .spi_mosi_in, .spi_miso_out,
		.spi_miso_oe_n_out, .slow_clock_out, .second_tick_irq_out, .alarm_match_irq_out,
		.host_irq_out, .turn_on_event_out, .seconds_of_day_counter_out, .elapsed_day_counter_out);
	rtd_host_model rtd_host_model_i (.ref_clk_in(ref_clk_in), .spi_miso_in(miso_line),
		.spi_clk_out(spi_clk_in), .spi_cs_out(spi_cs_in), .spi_mosi_out(spi_mosi_in));
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
		num_checks++;
		if (seen !== want) begin
			fails++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, want);
		end
	endtask
	task automatic conclude();
		if (fails == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk_in);
		#1;
	endtask
	task automatic put(input logic [5:0] a, input logic [23:0] d);
		rtd_host_model_i.frame(1'b1, a, d, 32, rd);
		cyc(3);
	endtask
	task automatic get(input logic [5:0] a);
		rtd_host_model_i.frame(1'b0, a, 24'h5a_5a5a, 32, rd);
	endtask
	// Waits for the next second, bounded, and steps the reference count alike.
	task automatic tick();
		logic [TOD_W-1:0] last;
		int n;
		last = seconds_of_day_counter_out;
		n = 0;
		while (seconds_of_day_counter_out === last && n < 4000) begin
			cyc(1);
			n++;
		end
		exp_sec = (exp_sec == 86399) ? 0 : exp_sec + 1;
		if (exp_sec == 0) exp_day = (exp_day + 1) % 32768;
		check(seconds_of_day_counter_out, exp_sec, "seconds");
		check(elapsed_day_counter_out, exp_day, "day");
		check(second_tick_irq_out, 1, "tick flag");
	endtask
	task automatic rise(output int c);
		c = 0;
		while (slow_clock_out !== 1'b0 && c < 5000) begin
			cyc(1);
			c++;
		end
		while (slow_clock_out !== 1'b1 && c < 5000) begin
			cyc(1);
			c++;
		end
	endtask
	// ----------------------------------------------------------------
	// Stimulus
	// ----------------------------------------------------------------
	initial begin
		ref_clk_in = 1'b0;
		forever #10 ref_clk_in = ~ref_clk_in;
	end
	// About a dozen one-second steps of some 3000 cycles each fit well inside this limit.
	initial begin
		#(20 * 80000);
		fails++;
		conclude();
	end
	always @(posedge ref_clk_in) if (turn_on_event_out === 1'b1) wake_cnt++;
	initial begin
		{rst_in, crystal_present_in, system_on_in} = 3'b111;
		{second_tick_mask_in, alarm_match_mask_in} = 2'b00;
		{second_tick_clear_in, alarm_match_clear_in} = 2'b00;
		r = $urandom(32'h2db4_f8fb);
		exp_sec = 0;
		exp_day = 0;
		wake_cnt = 0;
		cyc(8);
		rst_in = 1'b0;
		check(seconds_of_day_counter_out, 0, "reset seconds");
		check(elapsed_day_counter_out, 0, "reset day");
		check({host_irq_out, alarm_match_irq_out}, 0, "reset flags");
		tick();
		r = $urandom % 86400;
		put(ADDR_TIME, 24'(r));
		exp_sec = r;
		rtd_host_model_i.frame(1'b0, ADDR_TIME, 24'h00_0003, 32, rd);
		rtd_host_model_i.frame(1'b1, ADDR_TIME, 24'h00_0007, 20, rd);
		get(ADDR_TIME);
		check(rd, r, "time readback");
		tick();
		put(ADDR_TIME, 24'h01_517e);
		put(ADDR_DAY, 24'h00_7ffe);
		exp_sec = 86398;
		exp_day = 32766;
		get(ADDR_DAY);
		check(rd, exp_day, "day readback");
		tick();
		tick();
		second_tick_clear_in = 1'b1;
		cyc(1);
		second_tick_clear_in = 1'b0;
		cyc(2);
		check({second_tick_irq_out, host_irq_out}, 0, "cleared flag");
		second_tick_mask_in = 1'b1;
		tick();
		cyc(2);
		check(host_irq_out, 0, "masked irq");
		second_tick_mask_in = 1'b0;
		cyc(2);
		check(host_irq_out, 1, "unmasked irq");
		for (int on = 0; on < 2; on++) begin
			system_on_in = on[0];
			tick();
			put(ADDR_ALARM, 24'(exp_sec + 2));
			put(ADDR_DAY_ALARM, 24'(exp_day));
			alarm_match_clear_in = 1'b1;
			cyc(1);
			alarm_match_clear_in = 1'b0;
			wake_cnt = 0;
			tick();
			cyc(2);
			check(alarm_match_irq_out, 0, "early alarm");
			tick();
			cyc(2);
			check(alarm_match_irq_out, 1, "alarm flag");
			check(wake_cnt, 1 - on, "turn-on pulses");
		end
		{second_tick_mask_in, alarm_match_mask_in} = 2'b11;
		cyc(2);
		check(host_irq_out, 0, "all masked");
		{second_tick_mask_in, alarm_match_mask_in} = 2'b01;
		cyc(2);
		check(host_irq_out, 1, "alarm masked only");
		alarm_match_mask_in = 1'b0;
		for (int m = 0; m < 2; m++) begin
			crystal_present_in = m[0];
			repeat (3) rise(per);
			check(per >= (m ? 1525 : 1562) && per <= (m ? 1526 : 1563), 1, "slow period");
		end
		conclude();
	end
endmodule // tb
